//--- design/pspi_port.sv
// Paged serial register port: mode-3 slave, page select, sample loader and data-ready pin.
`timescale 1ns/1ps
//
// Overview of operation
// (RULE1) Mode 3: clock idles high, sample second edge.
// (RULE2) Master keeps serial clock at 16 MHz or less.
// (RULE3) Output bits launched on falling clock edge.
// (RULE4) Input bits captured on rising clock edge.
// (RULE5) Output pin high impedance while select high.
// (RULE6) Output meaningful only after a read request.
// (RULE7) Full duplex: new command during read reply.
// (RULE8) Thirteen pages of 64 registers, one active.
// (RULE9) Registers 16 bits, two byte addresses each.
// (RULE10) Page select writes set, reads return page.
// (RULE11) Page select at byte address zero everywhere.
// (RULE12) Page codes: output, control, serial, filters.
// (RULE13) Write frame: flag one, address, data byte.
// (RULE14) Low byte at low address, high at upper.
// (RULE15) Master writes low byte before high byte.
// (RULE16) Only page select acts on lone low write.
// (RULE17) Page zero active after start-up.
// (RULE18) Master restores page zero before data reads.
// (RULE19) Sensor loads output registers autonomously.
// (RULE20) Pin two pulses high on new data.
// (RULE21) Master holds reset pin high normally.
// (RULE22) Read frame: flag zero, address, reply next frame.
// (RULE23) Master leaves two microsecond frame gap.
// (RULE24) Reset held low at least ten microseconds.
// (RULE25) Frames sixteen clocks, MSB first, select low.
module pspi_port (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic config_pin_two_o,
   output logic [7:0] active_page_select_o
);
   import pspi_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sclk_ff, cs_ff, din_ff;
   logic sclk_st_ff, cs_st_ff;

   always_ff @(posedge core_clk_i) begin
      sclk_ff <= {sclk_ff[1:0], sclk_i};
      cs_ff <= {cs_ff[1:0], cs_n_i};
      din_ff <= {din_ff[1:0], din_i};
   end

   // A pin change counts only once the second and third stages agree.
   wire sclk_agree = sclk_ff[1] == sclk_ff[2];
   wire cs_agree = cs_ff[1] == cs_ff[2];

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sclk_st_ff <= 1'h1;
         cs_st_ff <= 1'h1;
      end else begin
         if (sclk_agree) begin
            sclk_st_ff <= sclk_ff[2];
         end
         if (cs_agree) begin
            cs_st_ff <= cs_ff[2];
         end
      end
   end

   wire cs_active = ~cs_st_ff;
   wire sclk_rise = sclk_agree & sclk_ff[2] & ~sclk_st_ff & cs_active; // RULE1 RULE4
   wire sclk_fall = sclk_agree & ~sclk_ff[2] & sclk_st_ff & cs_active; // RULE3
   wire din_bit = din_ff[2];

   // ---------------------------------------------------------------
   // Frame receiver
   // ---------------------------------------------------------------
   logic [15:0] rx_ff;
   logic [4:0] bit_cnt_ff;
   logic [15:0] tx_ff;
   logic tx_valid_ff;
   logic frame_done_ff;

   wire frame_end = sclk_rise & (bit_cnt_ff == LAST_BIT_CNT); // RULE25
   wire [15:0] rx_next = {rx_ff[14:0], din_bit}; // RULE25
   pspi_frame_t cmd;
   assign cmd = pspi_frame_t'(rx_next); // RULE13 RULE22

   always_ff @(posedge core_clk_i) begin
      if (srst_i | ~cs_active) begin
         bit_cnt_ff <= BIT_CNT_ZERO;
      end else if (sclk_rise) begin
         bit_cnt_ff <= frame_end ? BIT_CNT_ZERO : bit_cnt_ff + BIT_CNT_ONE;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rx_ff <= 16'h0000;
      end else if (sclk_rise) begin
         rx_ff <= rx_next; // RULE4
      end
   end

   // ---------------------------------------------------------------
   // Page select and write path
   // ---------------------------------------------------------------
   logic [7:0] page_ff;
   logic [7:0] low_byte_ff;
   logic [6:0] low_addr_ff;
   logic low_pend_ff;
   logic rd_pend_ff;
   logic [6:0] rd_addr_ff;

   wire is_write = frame_end & (cmd.write == RW_WRITE);
   wire is_read = frame_end & (cmd.write != RW_WRITE);
   wire hit_page = cmd.addr[6:1] == ADDR_ACTIVE_PAGE_SELECT[6:1]; // RULE11
   wire page_wr = is_write & (cmd.addr == ADDR_ACTIVE_PAGE_SELECT); // RULE10 RULE16
   wire page_ok = page_ff < 8'(NUM_PAGES); // RULE8 RULE12
   wire upper_wr = is_write & cmd.addr[0] & ~hit_page & low_pend_ff
      & (low_addr_ff == {cmd.addr[6:1], 1'h0}) & page_ok; // RULE14 RULE16
   wire [MEM_AW-1:0] user_waddr = MEM_AW'(page_ff * REGS_PER_PAGE) + MEM_AW'(cmd.addr[6:1]); // RULE8

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         page_ff <= PAGE_RESET; // RULE17
         low_pend_ff <= 1'h0;
         low_byte_ff <= 8'h00;
         low_addr_ff <= 7'h00;
      end else if (is_write) begin
         if (page_wr) begin
            page_ff <= cmd.data; // RULE10
         end
         low_pend_ff <= ~cmd.addr[0] & ~hit_page; // RULE16
         low_byte_ff <= cmd.data; // RULE14
         low_addr_ff <= cmd.addr;
      end
   end

   assign active_page_select_o = page_ff;

   // ---------------------------------------------------------------
   // Sample loader and data-ready pulse
   // ---------------------------------------------------------------
   logic [12:0] smp_cnt_ff;
   logic [5:0] load_word_ff;
   logic loading_ff;
   logic [15:0] sample_ff;
   logic [3:0] drdy_cnt_ff;

   wire smp_tick = smp_cnt_ff == 13'(SAMPLE_CYCLES - 1);
   wire load_last = loading_ff & (load_word_ff == OUT_LAST_WORD);
   wire load_en = loading_ff & ~upper_wr; // RULE19

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         smp_cnt_ff <= 13'h0000;
         loading_ff <= 1'h0;
         load_word_ff <= OUT_FIRST_WORD;
         sample_ff <= 16'h0000;
      end else begin
         smp_cnt_ff <= smp_tick ? 13'h0000 : smp_cnt_ff + 13'h0001;
         if (smp_tick) begin
            loading_ff <= 1'h1; // RULE19
            load_word_ff <= OUT_FIRST_WORD;
            sample_ff <= sample_ff + 16'h0001;
         end else if (load_en) begin
            loading_ff <= ~load_last;
            load_word_ff <= load_word_ff + 6'h01;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         drdy_cnt_ff <= 4'h0;
      end else if (load_en & load_last) begin
         drdy_cnt_ff <= 4'(DRDY_CYCLES); // RULE20
      end else if (drdy_cnt_ff != 4'h0) begin
         drdy_cnt_ff <= drdy_cnt_ff - 4'h1;
      end
   end

   logic drdy_ff;

   // The pin comes from a flop so that the counter decode cannot glitch it.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         drdy_ff <= 1'h0;
      end else begin
         drdy_ff <= (load_en & load_last) | (drdy_cnt_ff > 4'h1); // RULE20
      end
   end

   assign config_pin_two_o = drdy_ff; // RULE20

   // ---------------------------------------------------------------
   // Memory write port
   // ---------------------------------------------------------------
   pspi_wr_t wr;
   assign wr.en = upper_wr | load_en;
   assign wr.addr = upper_wr ? user_waddr : MEM_AW'(load_word_ff);
   assign wr.data = upper_wr ? {cmd.data, low_byte_ff} : sample_ff ^ {10'h000, load_word_ff};

   // ---------------------------------------------------------------
   // Read path and transmitter
   // ---------------------------------------------------------------
   logic [15:0] rd_word;
   logic rd_fetch_ff;
   wire [MEM_AW-1:0] rd_maddr = MEM_AW'(page_ff * REGS_PER_PAGE) + MEM_AW'(rd_addr_ff[6:1]);

   pspi_mem u_mem (
      .core_clk_i(core_clk_i),
      .wr_i(wr),
      .rd_addr_i(rd_maddr),
      .rd_data_o(rd_word)
   );

   wire rd_page = rd_addr_ff[6:1] == ADDR_ACTIVE_PAGE_SELECT[6:1];
   wire [15:0] rd_value = rd_page ? {8'h00, page_ff} : (page_ok ? rd_word : 16'h0000); // RULE9

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rd_pend_ff <= 1'h0;
         rd_fetch_ff <= 1'h0;
         rd_addr_ff <= 7'h00;
      end else begin
         rd_fetch_ff <= rd_pend_ff;
         rd_pend_ff <= is_read; // RULE22
         if (is_read) begin
            rd_addr_ff <= cmd.addr;
         end
      end
   end

   // A load frame is primed three cycles after the read frame ends; the stall gap covers it.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_ff <= 16'h0000;
         tx_valid_ff <= 1'h0;
         frame_done_ff <= 1'h0;
      end else begin
         frame_done_ff <= frame_end;
         if (rd_fetch_ff) begin
            tx_ff <= rd_value; // RULE6 RULE7
            tx_valid_ff <= 1'h1;
         end else if (frame_done_ff) begin
            tx_ff <= 16'h0000; // RULE6
            tx_valid_ff <= 1'h0; // RULE6
         end else if (sclk_fall & (bit_cnt_ff != BIT_CNT_ZERO)) begin
            tx_ff <= {tx_ff[14:0], 1'h0}; // RULE3
         end
      end
   end

   assign dout_o = tx_ff[15]; // RULE3 RULE25
   assign dout_oe_o = cs_active; // RULE5

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_dout_hiz: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE5
      cs_st_ff |-> !dout_oe_o) else $error("Output driven while deselected.");
   chk_page_write: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE10
      page_wr |=> page_ff == $past(cmd.data)) else $error("Page select not updated.");
   chk_page_reset: assert property (@(posedge core_clk_i) // RULE17
      srst_i |=> page_ff == PAGE_RESET) else $error("Page not zero after reset.");
   chk_lone_low: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE16
      (is_write & ~cmd.addr[0]) |-> !upper_wr) else $error("Low byte wrote a register.");
   chk_upper_pair: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE14
      upper_wr |-> wr.data[7:0] == low_byte_ff) else $error("Low byte lost in pair.");
   chk_read_reply: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE22
      is_read |-> ##3 tx_valid_ff) else $error("Read reply not loaded.");
   chk_no_reply: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE6
      (is_write & ~rd_pend_ff & ~rd_fetch_ff) |-> ##2 !tx_valid_ff)
      else $error("Reply after a write frame.");
   chk_drdy_width: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE20
      $rose(config_pin_two_o) |-> config_pin_two_o [*5] ##1 !config_pin_two_o)
      else $error("Data-ready pulse width wrong.");
   chk_bit_count: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE25
      frame_end |=> bit_cnt_ff == BIT_CNT_ZERO) else $error("Bit count not cleared.");
   chk_loader_runs: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE19
      smp_tick |=> loading_ff) else $error("Sample load did not start.");
   chk_shift_msb: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE3
      (sclk_fall & (bit_cnt_ff != BIT_CNT_ZERO) & ~rd_fetch_ff & ~frame_done_ff)
      |=> tx_ff == {$past(tx_ff[14:0]), 1'h0}) else $error("Output bit not shifted.");
   chk_cancel_low: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE16
      (is_write & (cmd.addr[0] | hit_page)) |=> !low_pend_ff) else $error("Low byte kept.");
   chk_page_gate: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE8
      (frame_end & ~page_ok) |-> !upper_wr) else $error("Write to missing page.");
   chk_idle_low: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE6
      !tx_valid_ff |-> !dout_o) else $error("Output bit without read request.");
   chk_reply_clear: assert property (@(posedge core_clk_i) disable iff (srst_i) // RULE6
      (frame_done_ff & ~rd_fetch_ff) |=> !tx_valid_ff) else $error("Reply not cleared.");

   cov_read: cover property (@(posedge core_clk_i) disable iff (srst_i) is_read);
   cov_pair: cover property (@(posedge core_clk_i) disable iff (srst_i) upper_wr);
   cov_page: cover property (@(posedge core_clk_i) disable iff (srst_i) page_wr);
   cov_drdy: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(config_pin_two_o));
endmodule

//--- design/pspi_pkg.sv
// Package of constants, types and the register map for the paged serial register port.
package pspi_pkg;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned RW_BIT = 15;
   localparam int unsigned ADDR_MSB = 14;
   localparam int unsigned ADDR_LSB = 8;
   localparam int unsigned DATA_MSB = 7;
   localparam logic RW_WRITE = 1'h1;
   localparam logic [4:0] LAST_BIT_CNT = 5'h0F;
   localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
   localparam logic [4:0] BIT_CNT_ONE = 5'h01;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int unsigned NUM_PAGES = 13;
   localparam int unsigned REGS_PER_PAGE = 64;
   localparam int unsigned MEM_WORDS = NUM_PAGES * REGS_PER_PAGE;
   localparam int unsigned MEM_AW = 10;
   localparam logic [6:0] ADDR_ACTIVE_PAGE_SELECT = 7'h00;
   localparam logic [7:0] PAGE_OUTPUT = 8'h00;
   localparam logic [7:0] PAGE_CONTROL = 8'h03;
   localparam logic [7:0] PAGE_SERIAL = 8'h04;
   localparam logic [7:0] PAGE_FILTER_FIRST = 8'h05;
   localparam logic [7:0] PAGE_FILTER_LAST = 8'h0C;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   // Output data word addresses on page zero that the sample loader fills.
   localparam logic [5:0] OUT_FIRST_WORD = 6'h07;
   localparam logic [5:0] OUT_LAST_WORD = 6'h2B;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SAMPLE_HZ = 3200;
   localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned DRDY_PULSE_NS = 200;
   localparam int unsigned DRDY_CYCLES = (DRDY_PULSE_NS * 25 + 999) / 1000;

   typedef struct packed {
      logic write;
      logic [6:0] addr;
      logic [7:0] data;
   } pspi_frame_t;

   typedef struct packed {
      logic en;
      logic [MEM_AW-1:0] addr;
      logic [15:0] data;
   } pspi_wr_t;
endpackage

//--- design/pspi_mem.sv
// Register storage of all pages with registered read data.
`timescale 1ns/1ps
module pspi_mem (
   input wire logic core_clk_i,
   input wire pspi_pkg::pspi_wr_t wr_i,
   input wire logic [pspi_pkg::MEM_AW-1:0] rd_addr_i,
   output logic [15:0] rd_data_o
);
   import pspi_pkg::*;
   logic [15:0] mem [MEM_WORDS];

   always_ff @(posedge core_clk_i) begin
      if (wr_i.en) begin
         mem[wr_i.addr] <= wr_i.data;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule

//--- verification/pspi_master.sv
// Serial bus master model that drives mode-3 frames into the port.
`timescale 1ns/1ps
module pspi_master (
   input wire logic core_clk_i,
   input wire logic miso_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o
);
   // ---------------------------------------------------------------
   // Frame transfer
   // ---------------------------------------------------------------
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end

   // Four core cycles a half period give a 320 ns link clock.
   task automatic half();
      repeat (4) @(negedge core_clk_i);
   endtask

   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      cs_n_o = 1'b0;
      half();
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         din_o = tx[i];
         half();
         sclk_o = 1'b1;
         half();
         rx[i] = miso_i;
      end
      cs_n_o = 1'b1;
      din_o = ~din_o;
      repeat (52) @(negedge core_clk_i);
   endtask
endmodule

//--- verification/pspi_port_test.sv
// Self-checking bench for the paged serial register port.
`timescale 1ns/1ps
module pspi_port_test;
   import pspi_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic core_clk_i;
   logic srst_i;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic ready;
   logic miso;
   logic [7:0] page;
   logic [15:0] rx;
   logic [15:0] v0;
   logic [7:0] codes [11] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                              8'h0A, 8'h0B, 8'h0C};
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   int hi = 0;

   // A released line shows the inverse of the last bit so a stale bit never reads as valid.
   assign miso = dout_oe ? dout : ~dout;

   pspi_port dut_u (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .sclk_i(sclk),
      .cs_n_i(cs_n),
      .din_i(din),
      .dout_o(dout),
      .dout_oe_o(dout_oe),
      .config_pin_two_o(ready),
      .active_page_select_o(page)
   );

   pspi_master master_u (
      .core_clk_i(core_clk_i),
      .miso_i(miso),
      .sclk_o(sclk),
      .cs_n_o(cs_n),
      .din_o(din)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      master_u.xfer({RW_WRITE, a, d}, rx);
   endtask

   // The reply is fetched while the next read request shifts in.
   task automatic fetch(input logic [6:0] a);
      master_u.xfer({1'b0, a, 8'h00}, rx);
      master_u.xfer({1'b0, ADDR_ACTIVE_PAGE_SELECT, 8'h00}, rx);
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      fetch(a);
      chk(rx, exp);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      srst_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      chk({8'h00, page}, {8'h00, PAGE_RESET});
      rd(ADDR_ACTIVE_PAGE_SELECT, 16'h0000);
      chk({15'h0000, dout_oe}, 16'h0000);
      $display("test reset done");
      foreach (codes[k]) begin
         wr(ADDR_ACTIVE_PAGE_SELECT, codes[k]);
         chk({8'h00, page}, {8'h00, codes[k]});
         rd(ADDR_ACTIVE_PAGE_SELECT, {8'h00, codes[k]});
      end
      $display("test page codes done");
      wr(ADDR_ACTIVE_PAGE_SELECT, PAGE_CONTROL);
      wr(7'h06, 8'h11);
      wr(7'h07, 8'hA2);
      chk(rx, 16'h0000);
      rd(7'h06, 16'hA211);
      rd(7'h07, 16'hA211);
      wr(7'h06, 8'h33);
      rd(7'h06, 16'hA211);
      wr(ADDR_ACTIVE_PAGE_SELECT, PAGE_SERIAL);
      wr(7'h06, 8'h55);
      wr(7'h07, 8'h66);
      rd(7'h06, 16'h6655);
      wr(ADDR_ACTIVE_PAGE_SELECT, PAGE_CONTROL);
      rd(7'h06, 16'hA211);
      wr(ADDR_ACTIVE_PAGE_SELECT, 8'h0D);
      rd(ADDR_ACTIVE_PAGE_SELECT, 16'h000D);
      rd(7'h06, 16'h0000);
      $display("test byte writes done");
      wr(ADDR_ACTIVE_PAGE_SELECT, PAGE_OUTPUT);
      chk({8'h00, page}, {8'h00, PAGE_OUTPUT});
      fetch({OUT_FIRST_WORD, 1'b0});
      v0 = rx;
      for (int n = 0; n < 100 && ready === 1'b1; n++) @(negedge core_clk_i);
      for (int n = 0; n < SAMPLE_CYCLES + 100 && ready !== 1'b1; n++) @(negedge core_clk_i);
      while (ready === 1'b1 && hi < 100) begin
         hi++;
         @(negedge core_clk_i);
      end
      chk(hi[15:0], DRDY_CYCLES[15:0]);
      fetch({OUT_FIRST_WORD, 1'b0});
      chk({15'h0000, rx !== v0}, 16'h0001);
      $display("test data ready done");
      wr(ADDR_ACTIVE_PAGE_SELECT, PAGE_FILTER_LAST);
      srst_i = 1'b1;
      repeat (250) @(negedge core_clk_i);
      srst_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      chk({8'h00, page}, {8'h00, PAGE_RESET});
      rd(ADDR_ACTIVE_PAGE_SELECT, {8'h00, PAGE_RESET});
      $display("test mid-run reset done");
      end_sim();
   end
endmodule
